// >>> core/tpwc_timer.v
// Purpose: 16-bit timer with pulse width capture, compare and output preset.
// Assumes: AHB-Lite slave, zero wait states, single word transfers.
// Notes:   Capture pins pass a synchroniser and a two-sample filter.
`timescale 1ns/100ps
`default_nettype none
`include "tpwc_regs.vh"

// Overview of operation
// - Free-running: input B edge captures into A
// - Free-running: input A edge captures into B
// - Reverse phase of input A captures into A
// - Edge-clear mode: capture into B, clear counter
// - A trigger selectable; B always input A
// - Overflow flag sticky until written zero
// - No irq A on reverse phase capture
// - No toggle on B match when disabled
// - Stopped: presets drive output, default low
// - Preset pair 10 drives output high
// - 01 low, 00 unchanged, 11 forbidden
// - Start keeps level from last preset
// - Output toggles at each irq A when TPWC_OUT_INV_A is set
// - Capture now, interrupt at next count clock
// - Edge valid after two equal samples
// - Capture edges ignored while stopped
module tpwc_timer
(
    // Clock and reset
    input  wire        MCLK,
    input  wire        RST,
    // AHB-Lite slave
    input  wire        HSEL,
    input  wire [11:0] HADDR,
    input  wire [1:0]  HTRANS,
    input  wire        HWRITE,
    input  wire [2:0]  HSIZE,
    input  wire        HREADY,
    input  wire [31:0] HWDATA,
    output reg  [31:0] HRDATA,
    output reg         HREADYOUT,
    output reg         HRESP,
    // Capture inputs
    input  wire        CAPTURE_INPUT_A,
    input  wire        CAPTURE_INPUT_B,
    // Timer output and interrupts
    output reg         TIMER_OUTPUT_PIN,
    output reg         MATCH_CAPTURE_IRQ_A,
    output reg         IRQ_B
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    reg  [15:0]                  main_counter_q;
    reg  [15:0]                  capture_compare_a_q;
    reg  [15:0]                  capture_compare_b_q;
    reg  [1:0]                   mode_q;
    reg                          overflow_flag_q;
    reg  [`TPWC_CAPCTL_W-1:0]    capture_control_q;
    reg  [`TPWC_OUTCTL_W-1:0]    output_control_q;
    reg  [`TPWC_PRESCALE_W-1:0]  prescaler_mode_q;
    reg                          cap_a_pend_q;
    reg                          cap_b_pend_q;
    reg                          wr_pend_q;
    reg  [`TPWC_IDX_W-1:0]       wr_idx_q;

    wire                         count_tick;
    wire                         running;
    wire                         in_a_valid;
    wire                         in_a_reverse;
    wire                         in_b_valid;
    wire                         in_b_reverse;
    wire                         addr_phase;
    wire                         bus_write;
    wire                         cap_a_event;
    wire                         cap_a_irq_event;
    wire                         cap_b_event;
    wire                         match_a;
    wire                         match_b;
    wire                         fire_a;
    wire                         fire_b;
    wire                         edge_clear;
    wire                         match_clear;
    wire [1:0]                   preset_pair;

    ////////////////////////////////////////////////////////////////////////////
    // Register index decode

    function [`TPWC_IDX_W-1:0] reg_index;
        input [11:0] addr;
        begin
            if (addr[11:5] == `TPWC_ADDR_HI_ZERO && addr[4:2] <= 3'h6)
                reg_index = {1'b0, addr[4:2]};
            else
                reg_index = `TPWC_IDX_NONE;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Count clock and capture input filters

    tpwc_count_clock u_count_clock
    (
        .clk     (MCLK),
        .rst     (RST),
        .div_sel (prescaler_mode_q[`TPWC_PRE_DIV_LO+1:`TPWC_PRE_DIV_LO]),
        .tick    (count_tick)
    );

    assign running = (mode_q != `TPWC_MODE_STOP);

    tpwc_edge_filter u_filter_a
    (
        .clk          (MCLK),
        .rst          (RST),
        .run          (running),
        .sample_en    (count_tick),
        .edge_sel     (prescaler_mode_q[`TPWC_PRE_EDGE_A_LO+1:`TPWC_PRE_EDGE_A_LO]),
        .pin_in       (CAPTURE_INPUT_A),
        .valid_edge   (in_a_valid),
        .reverse_edge (in_a_reverse)
    );

    tpwc_edge_filter u_filter_b
    (
        .clk          (MCLK),
        .rst          (RST),
        .run          (running),
        .sample_en    (count_tick),
        .edge_sel     (prescaler_mode_q[`TPWC_PRE_EDGE_B_LO+1:`TPWC_PRE_EDGE_B_LO]),
        .pin_in       (CAPTURE_INPUT_B),
        .valid_edge   (in_b_valid),
        .reverse_edge (in_b_reverse)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Capture and compare events

    assign cap_a_event = capture_control_q[`TPWC_CAP_A_CAPTURE] &
                         (capture_control_q[`TPWC_CAP_A_REVERSE] ? in_a_reverse : in_b_valid);
    assign cap_a_irq_event = capture_control_q[`TPWC_CAP_A_CAPTURE] &
                             ~capture_control_q[`TPWC_CAP_A_REVERSE] & in_b_valid;
    assign cap_b_event = capture_control_q[`TPWC_CAP_B_CAPTURE] & in_a_valid;

    assign match_a = running & count_tick & ~capture_control_q[`TPWC_CAP_A_CAPTURE] &
                     (main_counter_q == capture_compare_a_q);
    assign match_b = running & count_tick & ~capture_control_q[`TPWC_CAP_B_CAPTURE] &
                     (main_counter_q == capture_compare_b_q);

    // interrupt one count clock after capture
    assign fire_a = (count_tick & cap_a_pend_q) | match_a;
    assign fire_b = (count_tick & cap_b_pend_q) | match_b;

    assign edge_clear  = (mode_q == `TPWC_MODE_EDGECLR) & in_a_valid;
    assign match_clear = (mode_q == `TPWC_MODE_MATCHCLR) & match_a;

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite address and data phase tracking

    assign addr_phase = HSEL & HTRANS[1] & HREADY;
    assign bus_write  = wr_pend_q;

    always @(posedge MCLK)
    begin
        if (RST)
        begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= `TPWC_IDX_NONE;
            HRDATA    <= `TPWC_WORD_ZERO;
            HREADYOUT <= 1'b1;
            HRESP     <= `TPWC_HRESP_OKAY;
        end
        else
        begin
            HREADYOUT <= 1'b1;
            HRESP     <= `TPWC_HRESP_OKAY;
            if (HREADY)
            begin
                wr_pend_q <= addr_phase & HWRITE;
                wr_idx_q  <= reg_index(HADDR);
            end
            if (addr_phase && !HWRITE)
            begin
                case (reg_index(HADDR))
                    `TPWC_IDX_COUNT:    HRDATA <= {16'h0000, main_counter_q};
                    `TPWC_IDX_CC_A:     HRDATA <= {16'h0000, capture_compare_a_q};
                    `TPWC_IDX_CC_B:     HRDATA <= {16'h0000, capture_compare_b_q};
                    `TPWC_IDX_MODE:     HRDATA <= {28'h000_0000, mode_q, 1'b0,
                                                   overflow_flag_q};
                    `TPWC_IDX_CAPCTL:   HRDATA <= {29'h0000_0000, capture_control_q};
                    `TPWC_IDX_OUTCTL:   HRDATA <= {24'h00_0000, output_control_q};
                    `TPWC_IDX_PRESCALE: HRDATA <= {26'h000_0000, prescaler_mode_q};
                    default:            HRDATA <= `TPWC_WORD_ZERO;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    assign preset_pair = HWDATA[`TPWC_OUT_PRE_HIGH:`TPWC_OUT_PRE_LOW];

    always @(posedge MCLK)
    begin
        if (RST)
        begin
            mode_q            <= `TPWC_MODE_STOP;
            capture_control_q <= 3'h0;
            output_control_q  <= 8'h00;
            prescaler_mode_q  <= 6'h00;
        end
        else if (bus_write)
        begin
            case (wr_idx_q)
                `TPWC_IDX_MODE:     mode_q <= HWDATA[`TPWC_MODE_HI:`TPWC_MODE_LO];
                `TPWC_IDX_CAPCTL:   capture_control_q <= HWDATA[`TPWC_CAPCTL_W-1:0];
                `TPWC_IDX_OUTCTL:   output_control_q <= HWDATA[`TPWC_OUTCTL_W-1:0];
                `TPWC_IDX_PRESCALE: prescaler_mode_q <= HWDATA[`TPWC_PRESCALE_W-1:0];
                default:            mode_q <= mode_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter, capture registers and overflow flag

    always @(posedge MCLK)
    begin
        if (RST)
        begin
            main_counter_q      <= `TPWC_CNT_ZERO;
            capture_compare_a_q <= `TPWC_CNT_ZERO;
            capture_compare_b_q <= `TPWC_CNT_ZERO;
            overflow_flag_q     <= 1'b0;
        end
        else
        begin
            // Software writes; a capture in the same cycle takes precedence
            if (bus_write && wr_idx_q == `TPWC_IDX_CC_A)
                capture_compare_a_q <= HWDATA[15:0];
            if (bus_write && wr_idx_q == `TPWC_IDX_CC_B)
                capture_compare_b_q <= HWDATA[15:0];
            if (bus_write && wr_idx_q == `TPWC_IDX_MODE && !HWDATA[`TPWC_MODE_OVF])
                overflow_flag_q <= 1'b0;

            if (!running)
                main_counter_q <= `TPWC_CNT_ZERO;
            else
            begin
                if (cap_a_event)
                    capture_compare_a_q <= main_counter_q;
                if (cap_b_event)
                    capture_compare_b_q <= main_counter_q;
                if (edge_clear || match_clear)
                    main_counter_q <= `TPWC_CNT_ZERO;
                else if (count_tick)
                    main_counter_q <= main_counter_q + 16'h0001;
                if (count_tick && main_counter_q == `TPWC_CNT_MAX && !edge_clear)
                    overflow_flag_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt pulses

    always @(posedge MCLK)
    begin
        if (RST)
        begin
            cap_a_pend_q        <= 1'b0;
            cap_b_pend_q        <= 1'b0;
            MATCH_CAPTURE_IRQ_A <= 1'b0;
            IRQ_B               <= 1'b0;
        end
        else
        begin
            cap_a_pend_q        <= running & (cap_a_irq_event | (cap_a_pend_q & ~count_tick));
            cap_b_pend_q        <= running & (cap_b_event | (cap_b_pend_q & ~count_tick));
            MATCH_CAPTURE_IRQ_A <= running & fire_a;
            IRQ_B               <= running & fire_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timer output level

    always @(posedge MCLK)
    begin
        if (RST)
            TIMER_OUTPUT_PIN <= 1'b0;
        else if (!running)
        begin
            if (bus_write && wr_idx_q == `TPWC_IDX_OUTCTL)
            begin
                if (preset_pair == `TPWC_PRESET_HIGH)
                    TIMER_OUTPUT_PIN <= 1'b1;
                else if (preset_pair == `TPWC_PRESET_LOW)
                    TIMER_OUTPUT_PIN <= 1'b0;
            end
        end
        else
            TIMER_OUTPUT_PIN <= TIMER_OUTPUT_PIN ^
                                (fire_a & output_control_q[`TPWC_OUT_INV_A]) ^
                                (match_b & output_control_q[`TPWC_OUT_INV_B]);
    end

endmodule
`default_nettype wire

// >>> core/tpwc_regs.vh
// Purpose: Register map, field positions and codes of the pulse width capture timer.
// Assumes: Included by bare name from the core design files.
// Notes:   Byte address is four times the register index.
`ifndef TPWC_REGS_VH
`define TPWC_REGS_VH

// Register indices (word addresses)
`define TPWC_IDX_W          4
`define TPWC_IDX_COUNT      4'h0
`define TPWC_IDX_CC_A       4'h1
`define TPWC_IDX_CC_B       4'h2
`define TPWC_IDX_MODE       4'h3
`define TPWC_IDX_CAPCTL     4'h4
`define TPWC_IDX_OUTCTL     4'h5
`define TPWC_IDX_PRESCALE   4'h6
`define TPWC_IDX_NONE       4'hF
`define TPWC_ADDR_HI_ZERO   7'h00

// mode_control_reg fields
`define TPWC_MODE_OVF       0
`define TPWC_MODE_LO        2
`define TPWC_MODE_HI        3
`define TPWC_MODE_STOP      2'h0
`define TPWC_MODE_FREE      2'h1
`define TPWC_MODE_EDGECLR   2'h2
`define TPWC_MODE_MATCHCLR  2'h3

// capture_control_reg fields
`define TPWC_CAP_A_CAPTURE  0
`define TPWC_CAP_A_REVERSE  1
`define TPWC_CAP_B_CAPTURE  2
`define TPWC_CAPCTL_W       3

// timer_output_control fields
`define TPWC_OUT_ENABLE     0
`define TPWC_OUT_INV_A      1
`define TPWC_OUT_PRE_LOW    2
`define TPWC_OUT_PRE_HIGH   3
`define TPWC_OUT_INV_B      4
`define TPWC_OUT_SP_EN      5
`define TPWC_OUT_SP_TRIG    6
`define TPWC_OUTCTL_W       8
`define TPWC_PRESET_HIGH    2'h2
`define TPWC_PRESET_LOW     2'h1

// prescaler_mode_reg fields
`define TPWC_PRE_EDGE_A_LO  0
`define TPWC_PRE_EDGE_B_LO  2
`define TPWC_PRE_DIV_LO     4
`define TPWC_PRESCALE_W     6
`define TPWC_EDGE_FALL      2'h0
`define TPWC_EDGE_RISE      2'h1
`define TPWC_EDGE_NONE      2'h2
`define TPWC_EDGE_BOTH      2'h3

// Count clock divisor codes: divide by 1, 2, 4, 8
`define TPWC_DIV_W          3
`define TPWC_DIV_MASK1      3'h0
`define TPWC_DIV_MASK2      3'h1
`define TPWC_DIV_MASK4      3'h3
`define TPWC_DIV_MASK8      3'h7

// Counter values and bus constants
`define TPWC_CNT_ZERO       16'h0000
`define TPWC_CNT_MAX        16'hFFFF
`define TPWC_WORD_ZERO      32'h0000_0000
`define TPWC_HRESP_OKAY     1'b0

`endif

// >>> core/tpwc_count_clock.v
// Purpose: Count clock enable divider.
// Assumes: One clock domain, synchronous active high reset.
// Notes:   Emits a one-cycle enable every 1, 2, 4 or 8 clocks.
`timescale 1ns/100ps
`default_nettype none
`include "tpwc_regs.vh"

module tpwc_count_clock
(
    // Clock and reset
    input  wire       clk,
    input  wire       rst,
    // Control
    input  wire [1:0] div_sel,
    // Count clock enable
    output wire       tick
);

    reg  [`TPWC_DIV_W-1:0] div_q;
    reg  [`TPWC_DIV_W-1:0] mask;

    always @*
    begin
        case (div_sel)
            2'h0:    mask = `TPWC_DIV_MASK1;
            2'h1:    mask = `TPWC_DIV_MASK2;
            2'h2:    mask = `TPWC_DIV_MASK4;
            default: mask = `TPWC_DIV_MASK8;
        endcase
    end

    assign tick = ((div_q & mask) == mask);

    always @(posedge clk)
    begin
        if (rst)
            div_q <= `TPWC_DIV_MASK1;
        else
            div_q <= div_q + 3'h1;
    end

endmodule
`default_nettype wire

// >>> core/tpwc_edge_filter.v
// Purpose: Pin synchroniser, two-sample noise filter and edge classifier.
// Assumes: Sample enable is the count clock; run low while the timer stops.
// Notes:   Edge pulses are combinational and aligned with the sample enable.
`timescale 1ns/100ps
`default_nettype none
`include "tpwc_regs.vh"

module tpwc_edge_filter
(
    // Clock and reset
    input  wire       clk,
    input  wire       rst,
    // Control
    input  wire       run,
    input  wire       sample_en,
    input  wire [1:0] edge_sel,
    // Pin
    input  wire       pin_in,
    // Detected edges
    output wire       valid_edge,
    output wire       reverse_edge
);

    reg  sync1_q;
    reg  sync2_q;
    reg  sync3_q;
    reg  stable_q;
    reg  samp_q;
    reg  level_q;
    wire change;
    wire rise;
    wire fall;
    wire sel_rise;
    wire sel_fall;

    // Three-flop synchroniser; a change counts once stages two and three agree
    always @(posedge clk)
    begin
        if (rst)
        begin
            sync1_q  <= 1'b0;
            sync2_q  <= 1'b0;
            sync3_q  <= 1'b0;
            stable_q <= 1'b0;
        end
        else
        begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            if (sync2_q == sync3_q)
                stable_q <= sync3_q;
        end
    end

    assign change = run & sample_en & (stable_q == samp_q) & (stable_q != level_q);
    assign rise   = change & stable_q;
    assign fall   = change & ~stable_q;

    always @(posedge clk)
    begin
        if (rst || !run)
        begin
            samp_q  <= 1'b0;
            level_q <= 1'b0;
        end
        else if (sample_en)
        begin
            samp_q <= stable_q;
            if (change)
                level_q <= stable_q;
        end
    end

    assign sel_rise     = (edge_sel == `TPWC_EDGE_RISE) | (edge_sel == `TPWC_EDGE_BOTH);
    assign sel_fall     = (edge_sel == `TPWC_EDGE_FALL) | (edge_sel == `TPWC_EDGE_BOTH);
    assign valid_edge   = (rise & sel_rise) | (fall & sel_fall);
    assign reverse_edge = (rise & sel_fall) | (fall & sel_rise);

endmodule
`default_nettype wire

// >>> testbench/tpwc_timer_monitor.sv
// Purpose: Port-level checker for the pulse width capture timer.
// Assumes: One clock domain, synchronous active high reset.
// Notes:   Mode and output control are shadowed from bus writes.
`timescale 1ns/100ps
`default_nettype none
module tpwc_timer_monitor
(
    // Clock and reset
    input wire logic        MCLK,
    input wire logic        RST,
    // Bus
    input wire logic        HSEL,
    input wire logic [11:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic        HREADY,
    input wire logic [31:0] HWDATA,
    // Timer outputs
    input wire logic        TIMER_OUTPUT_PIN,
    input wire logic        MATCH_CAPTURE_IRQ_A,
    input wire logic        IRQ_B
);
    logic       wr_q;
    logic [2:0] idx_q;
    logic [1:0] mode_q;
    logic [4:0] out_q;
    logic [1:0] stop_q;
    logic [1:0] run_q;
    logic [1:0] quiet_q;
    logic       stopped;
    assign stopped = (stop_q == 2'h3);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);
    // Shadow registers and saturating age counters
    always @(posedge MCLK)
    begin
        if (RST)
        begin
            wr_q <= 1'b0;
            idx_q <= 3'h0;
            mode_q <= 2'h0;
            out_q <= 5'h00;
            stop_q <= 2'h0;
            run_q <= 2'h0;
            quiet_q <= 2'h0;
        end
        else
        begin
            wr_q <= HSEL && HTRANS[1] && HREADY && HWRITE && (HADDR[11:5] == 7'h00);
            idx_q <= HADDR[4:2];
            if (wr_q && idx_q == 3'h3)
                mode_q <= HWDATA[3:2];
            if (wr_q && idx_q == 3'h5)
                out_q <= HWDATA[4:0];
            stop_q <= (mode_q != 2'h0) ? 2'h0 : stop_q + {1'b0, !stopped};
            run_q <= (mode_q == 2'h0) ? 2'h0 : run_q + {1'b0, run_q != 2'h3};
            quiet_q <= wr_q ? 2'h0 : quiet_q + {1'b0, quiet_q != 2'h3};
        end
    end
    a_irq_a_pulse: assert property (
        MATCH_CAPTURE_IRQ_A |=> !MATCH_CAPTURE_IRQ_A) else $error("irq a wider than one cycle");
    a_irq_b_pulse: assert property (
        IRQ_B |=> !IRQ_B) else $error("irq b wider than one cycle");
    a_stop_quiet: assert property (
        stopped |-> !MATCH_CAPTURE_IRQ_A && !IRQ_B) else $error("interrupt while stopped");
    a_stop_hold: assert property (
        stopped && quiet_q == 2'h3 |-> $stable(TIMER_OUTPUT_PIN)) else $error("pin moved stopped");
    a_preset_high: assert property (
        wr_q && idx_q == 3'h5 && stopped && HWDATA[3:2] == 2'h2 |-> ##2 TIMER_OUTPUT_PIN)
        else $error("preset high not driven");
    a_preset_low: assert property (
        wr_q && idx_q == 3'h5 && stopped && HWDATA[3:2] == 2'h1 |-> ##2 !TIMER_OUTPUT_PIN)
        else $error("preset low not driven");
    a_preset_keep: assert property (
        wr_q && idx_q == 3'h5 && stopped && HWDATA[3:2] == 2'h0
        |-> ##2 TIMER_OUTPUT_PIN == $past(TIMER_OUTPUT_PIN, 2)) else $error("preset 00 moved pin");
    a_run_hold: assert property (
        run_q == 2'h3 && quiet_q == 2'h3 && !out_q[1] && !out_q[4] |-> $stable(TIMER_OUTPUT_PIN))
        else $error("pin toggled with inversion off");
    a_toggle_irq: assert property (
        run_q == 2'h3 && quiet_q == 2'h3 && out_q[1] && !out_q[4]
        |-> $changed(TIMER_OUTPUT_PIN) == MATCH_CAPTURE_IRQ_A) else $error("toggle not at irq a");
endmodule
bind tpwc_timer tpwc_timer_monitor tpwc_timer_monitor_inst
(
    .MCLK(MCLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HREADY(HREADY), .HWDATA(HWDATA), .TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN),
    .MATCH_CAPTURE_IRQ_A(MATCH_CAPTURE_IRQ_A), .IRQ_B(IRQ_B)
);
`default_nettype wire

// >>> testbench/tpwc_pulse_src.sv
// Purpose: External pulse source on the two capture pins.
// Assumes: Caller steps levels just after a rising clock edge.
// Notes:   Pins are driven at all times, low when idle.
`timescale 1ns/100ps
`default_nettype none
module tpwc_pulse_src
(
    // Capture pins
    output var logic pin_a,
    output var logic pin_b
);
    initial
    begin
        pin_a = 1'b0;
        pin_b = 1'b0;
    end
    // callers hold each level well beyond two count clocks
    task automatic drive(input logic sel_b, input logic lvl);
        begin
            if (sel_b)
                pin_b <= lvl;
            else
                pin_a <= lvl;
        end
    endtask
endmodule
`default_nettype wire

// >>> testbench/test_tpwc_timer.sv
// Purpose: Register-level tests of the pulse width capture timer.
// Assumes: Count clock divide by 1 or 2, zero wait state bus.
// Notes:   Widths are measured as 16-bit differences of captures.
`timescale 1ns/100ps
`default_nettype none
module test_tpwc_timer;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        pin_a;
    logic        pin_b;
    logic        pin_out;
    logic        irq_a;
    logic        irq_b;
    logic        pin_prev = 1'b0;
    logic [15:0] dw;
    logic [31:0] v1;
    logic [31:0] v2;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          n_ia = 0;
    int          n_ib = 0;
    int          n_tg = 0;
    int          ia0;
    int          ib0;
    int          tg0;
    tpwc_timer tpwc_timer_inst
    (
        .MCLK(mclk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(hsize), .HREADY(hreadyout), .HWDATA(hwdata), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .CAPTURE_INPUT_A(pin_a), .CAPTURE_INPUT_B(pin_b),
        .TIMER_OUTPUT_PIN(pin_out), .MATCH_CAPTURE_IRQ_A(irq_a), .IRQ_B(irq_b)
    );
    tpwc_pulse_src tpwc_pulse_src_inst
    (
        .pin_a(pin_a),
        .pin_b(pin_b)
    );
    always #25 mclk = ~mclk;
    always @(posedge mclk)
    begin
        n_ia += (irq_a === 1'b1);
        n_ib += (irq_b === 1'b1);
        n_tg += (pin_out !== pin_prev);
        pin_prev <= pin_out;
    end
    ////////////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
            if (n_mismatch == 0 && comparisons > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        begin
            comparisons++;
            if (got !== exp)
            begin
                n_mismatch++;
                $display("[FAIL] %s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task automatic wait_rdy;
        begin
            @(posedge mclk);
            while (hreadyout !== 1'b1)
                @(posedge mclk);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        begin
            hsel <= 1'b1;
            htrans <= 2'h2;
            hwrite <= w;
            haddr <= a;
            wait_rdy();
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            wait_rdy();
            r = hrdata;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        begin
            xfer(1'b1, a, d, r);
        end
    endtask
    task automatic rd(input string name, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        begin
            xfer(1'b0, a, 32'h0000_0000, r);
            check(name, exp, r);
            check("hresp", 32'h0, {31'h0, hresp});
        end
    endtask
    // Pulse one pin for w cycles, capture word at each edge, return the difference
    task automatic measure(input logic b, input int w, input logic [11:0] ra,
                           input logic [11:0] fa);
        begin
            ia0 = n_ia;
            ib0 = n_ib;
            tpwc_pulse_src_inst.drive(b, 1'b1);
            repeat (20) @(posedge mclk);
            xfer(1'b0, ra, 32'h0000_0000, v1);
            repeat (w - 22) @(posedge mclk);
            tpwc_pulse_src_inst.drive(b, 1'b0);
            repeat (20) @(posedge mclk);
            xfer(1'b0, fa, 32'h0000_0000, v2);
            dw = v2[15:0] - v1[15:0];
        end
    endtask
    task automatic preset(input logic [31:0] d, input logic exp);
        begin
            wr(12'h014, d);
            repeat (3) @(posedge mclk);
            check("output pin", {31'h0, exp}, {31'h0, pin_out});
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (80000) @(posedge mclk);
        n_mismatch++;
        $display("[FAIL] watchdog expired");
        summarize();
    end
    initial
    begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        for (int i = 0; i < 8; i++)
            rd("reset word", 12'(i * 4), 32'h0000_0000);
        check("pin after reset", 32'h0, {31'h0, pin_out});
        preset(32'h0000_0008, 1'b1);
        preset(32'h0000_0000, 1'b1);
        preset(32'h0000_0004, 1'b0);
        preset(32'h0000_0008, 1'b1);
        wr(12'h00C, 32'h0000_0004);
        repeat (20) @(posedge mclk);
        check("pin at start", 32'h1, {31'h0, pin_out});
        wr(12'h00C, 32'h0000_0000);
        wr(12'h014, 32'h0000_0004);
        wr(12'h018, 32'h0000_000F);
        wr(12'h010, 32'h0000_0005);
        measure(1'b0, 30, 12'h008, 12'h008);
        rd("capture b stopped", 12'h008, 32'h0000_0000);
        check("irq b stopped", 32'h0, n_ib - ib0);
        wr(12'h00C, 32'h0000_0004);
        xfer(1'b0, 12'h000, 32'h0000_0000, v1);
        xfer(1'b0, 12'h000, 32'h0000_0000, v2);
        check("count step", 32'h2, v2 - v1);
        measure(1'b0, 40, 12'h008, 12'h008);
        check("width a", 32'h28, {16'h0, dw});
        check("irq b count", 32'h2, n_ib - ib0);
        check("irq a quiet", 32'h0, n_ia - ia0);
        measure(1'b1, 50, 12'h004, 12'h004);
        check("width b", 32'h32, {16'h0, dw});
        check("irq a count", 32'h2, n_ia - ia0);
        wr(12'h00C, 32'h0000_0000);
        wr(12'h010, 32'h0000_0007);
        wr(12'h018, 32'h0000_0009);
        wr(12'h00C, 32'h0000_0004);
        measure(1'b0, 60, 12'h008, 12'h004);
        check("reverse width", 32'h3C, {16'h0, dw});
        check("reverse irq a", 32'h0, n_ia - ia0);
        check("reverse irq b", 32'h1, n_ib - ib0);
        repeat (65540) @(posedge mclk);
        rd("overflow set", 12'h00C, 32'h0000_0005);
        wr(12'h00C, 32'h0000_0005);
        rd("overflow kept", 12'h00C, 32'h0000_0005);
        wr(12'h00C, 32'h0000_0004);
        rd("overflow cleared", 12'h00C, 32'h0000_0004);
        wr(12'h00C, 32'h0000_0000);
        wr(12'h010, 32'h0000_0004);
        wr(12'h00C, 32'h0000_0008);
        for (int k = 0; k < 2; k++)
        begin
            tpwc_pulse_src_inst.drive(1'b0, 1'b1);
            repeat (20) @(posedge mclk);
            tpwc_pulse_src_inst.drive(1'b0, 1'b0);
            repeat (80) @(posedge mclk);
        end
        // Clear replaces one increment, so a 100-cycle period reads 99
        rd("edge clear period", 12'h008, 32'h0000_0063);
        wr(12'h00C, 32'h0000_0000);
        wr(12'h004, 32'h0000_0009);
        wr(12'h008, 32'h0000_0004);
        wr(12'h010, 32'h0000_0000);
        wr(12'h018, 32'h0000_0019);
        wr(12'h014, 32'h0000_0002);
        wr(12'h00C, 32'h0000_000C);
        repeat (20) @(posedge mclk);
        ia0 = n_ia;
        tg0 = n_tg;
        repeat (100) @(posedge mclk);
        check("match irq a", 32'h5, n_ia - ia0);
        check("toggles", 32'h5, n_tg - tg0);
        wr(12'h00C, 32'h0000_0000);
        summarize();
    end
endmodule
`default_nettype wire
